// File: hw/pfi_fault_irq_regs.sv
`timescale 1ns/1ps

// How it works
// - sense register at 0x07 reads the live monitored conditions, not history
// - sense bit 7 reads 0 when fuse supply pin grounded, 1 when high
// - sense bits 5..2 read 1 above 130, 125, 120, 110 degree thresholds
// - sense bit 1 reads 1 while input supply is below about 2.7 V
// - sense bit 0 follows the power-on enable pin level
// - sense bits after reset equal the monitored inputs, not a constant
// - status flags are sticky; writing 1 clears, writing 0 leaves unchanged
// - buck-fault flag bit 4 sets when buck 3 enters current limit
// - buck-fault flag bit 3 sets when buck 2 enters current limit
// - buck-fault flag bits 1 and 0 both set when buck 1 limits
// - a flag whose mask bit is 0 reaches the interrupt pin; 1 blocks
// - buck-fault mask holds bits 4, 3, 1, 0 matching the flags
// - buck-fault sense bits 4, 3, 1, 0 read live overcurrent state
// - buck-fault sense bits after reset reflect regulator state, not constant
// - fuse error flag sets when error checking finds a fuse content error
// - fuse/boost flag bit 6 sets when automatic fuse programming completes
// - fuse/boost flag bit 0 sets when boost regulator enters current limit
// - thermal flags set on threshold crossing in either direction
// - fuse-run sense bit reads 1 while automatic fuse sequence runs
module pfi_fault_irq_regs
(
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RST_N_I,
    // monitored conditions
    input  wire logic       FUSE_SUPPLY_PIN_I,
    input  wire logic [3:0] TEMP_ABOVE_I,
    input  wire logic       INPUT_UNDERVOLT_I,
    input  wire logic       POWER_ON_PIN_I,
    input  wire logic       BUCK3_OVERCURRENT_I,
    input  wire logic       BUCK2_OVERCURRENT_I,
    input  wire logic       BUCK1_OVERCURRENT_I,
    input  wire logic       FUSE_ERROR_I,
    input  wire logic       FUSE_PROGRAM_RUNNING_I,
    input  wire logic       BOOST_OVERCURRENT_I,
    // register port from the serial control interface
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic       REG_WR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_RD_I,
    output logic      [7:0] REG_RDATA_O,
    // interrupt pin
    output logic            IRQ_OUT_N_O
);

    pfi_pkg::pfi_state_s state_r;
    pfi_pkg::pfi_state_s state_nxt;

    logic [7:0] sense0;
    logic [7:0] sense1;
    logic [7:0] sense3;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] set3;
    logic       pending;
    logic       wr_stat0;
    logic       wr_stat1;
    logic       wr_stat3;
    logic       wr_mask0;
    logic       wr_mask1;
    logic       wr_mask3;
    logic [7:0] rd_value;

    // sticky flag update, set wins over clear
    function automatic logic [7:0] w1c_update
    (
        input logic [7:0] stat,
        input logic [7:0] set,
        input logic       wr_hit,
        input logic [7:0] wdata,
        input logic [7:0] bits
    );
        logic [7:0] clr;
        clr = wr_hit ? (wdata & bits) : 8'h00;
        return ((stat & ~clr) | set) & bits;
    endfunction : w1c_update

    // strobe qualified by one register address
    function automatic logic addr_hit
    (
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return strobe && (addr == target);
    endfunction : addr_hit

    // bits that went from 0 to 1 since the last edge
    function automatic logic [7:0] rise_bits
    (
        input logic [7:0] now,
        input logic [7:0] prev,
        input logic [7:0] bits
    );
        return now & ~prev & bits;
    endfunction : rise_bits

    // bits that went from 1 to 0 since the last edge
    function automatic logic [7:0] fall_bits
    (
        input logic [7:0] now,
        input logic [7:0] prev,
        input logic [7:0] bits
    );
        return prev & ~now & bits;
    endfunction : fall_bits

    // bits that moved either way since the last edge
    function automatic logic [7:0] change_bits
    (
        input logic [7:0] now,
        input logic [7:0] prev,
        input logic [7:0] bits
    );
        return (now ^ prev) & bits;
    endfunction : change_bits

    // mask write, unimplemented bits stay 0
    function automatic logic [7:0] mask_update
    (
        input logic [7:0] mask,
        input logic       wr_hit,
        input logic [7:0] wdata,
        input logic [7:0] bits
    );
        return wr_hit ? (wdata & bits) : mask;
    endfunction : mask_update

    // any flag set and not masked
    function automatic logic any_unmasked
    (
        input logic [7:0] stat,
        input logic [7:0] mask
    );
        return |(stat & ~mask);
    endfunction : any_unmasked

    // any unmasked flag in the whole state
    function automatic logic irq_pending
    (
        input pfi_pkg::pfi_state_s st
    );
        return any_unmasked(st.stat0, st.mask0)
             | any_unmasked(st.stat1, st.mask1)
             | any_unmasked(st.stat3, st.mask3);
    endfunction : irq_pending

    // reset image, edge history seeded from the live inputs
    function automatic pfi_pkg::pfi_state_s reset_state
    (
        input logic [7:0] s0,
        input logic [7:0] s1,
        input logic [7:0] s3
    );
        pfi_pkg::pfi_state_s st;
        st.prev0 = s0;
        st.prev1 = s1;
        st.prev3 = s3;
        st.stat0 = pfi_pkg::STAT_RST;
        st.mask0 = pfi_pkg::MASK_RST & pfi_pkg::REG0_BITS;
        st.stat1 = pfi_pkg::STAT_RST;
        st.mask1 = pfi_pkg::MASK_RST & pfi_pkg::REG1_BITS;
        st.stat3 = pfi_pkg::STAT_RST;
        st.mask3 = pfi_pkg::MASK_RST & pfi_pkg::REG3_BITS;
        st.rdata = pfi_pkg::RDATA_RST;
        st.irq_n = pfi_pkg::IRQ_N_RST;
        return st;
    endfunction : reset_state

    // status write decode
    always_comb
    begin
        wr_stat0 = addr_hit(REG_WR_I, REG_ADDR_I, pfi_pkg::STAT0_ADDR);
        wr_stat1 = addr_hit(REG_WR_I, REG_ADDR_I, pfi_pkg::STAT1_ADDR);
        wr_stat3 = addr_hit(REG_WR_I, REG_ADDR_I, pfi_pkg::STAT3_ADDR);
    end

    // mask write decode
    always_comb
    begin
        wr_mask0 = addr_hit(REG_WR_I, REG_ADDR_I, pfi_pkg::MASK0_ADDR);
        wr_mask1 = addr_hit(REG_WR_I, REG_ADDR_I, pfi_pkg::MASK1_ADDR);
        wr_mask3 = addr_hit(REG_WR_I, REG_ADDR_I, pfi_pkg::MASK3_ADDR);
    end

    // read mux, sense registers read live
    always_comb
    begin
        case (REG_ADDR_I)
            pfi_pkg::STAT0_ADDR:  rd_value = state_r.stat0;
            pfi_pkg::MASK0_ADDR:  rd_value = state_r.mask0;
            pfi_pkg::SENSE0_ADDR: rd_value = sense0;
            pfi_pkg::STAT1_ADDR:  rd_value = state_r.stat1;
            pfi_pkg::MASK1_ADDR:  rd_value = state_r.mask1;
            pfi_pkg::SENSE1_ADDR: rd_value = sense1;
            pfi_pkg::STAT3_ADDR:  rd_value = state_r.stat3;
            pfi_pkg::MASK3_ADDR:  rd_value = state_r.mask3;
            pfi_pkg::SENSE3_ADDR: rd_value = sense3;
            default:              rd_value = 8'h00;
        endcase
    end

    // live sense vectors
    always_comb
    begin
        sense0 = 8'h00;
        sense0[pfi_pkg::FUSE_SUPPLY_BIT] = FUSE_SUPPLY_PIN_I;
        sense0[pfi_pkg::TEMP_LSB +: pfi_pkg::TEMP_WIDTH] = TEMP_ABOVE_I;
        sense0[pfi_pkg::UNDERVOLT_BIT] = INPUT_UNDERVOLT_I;
        sense0[pfi_pkg::POWER_ON_BIT] = POWER_ON_PIN_I;
    end

    // live sense, buck group
    always_comb
    begin
        sense1 = 8'h00;
        sense1[pfi_pkg::BUCK3_BIT] = BUCK3_OVERCURRENT_I;
        sense1[pfi_pkg::BUCK2_BIT] = BUCK2_OVERCURRENT_I;
        sense1[pfi_pkg::BUCK1_HI_BIT] = BUCK1_OVERCURRENT_I;
        sense1[pfi_pkg::BUCK1_LO_BIT] = BUCK1_OVERCURRENT_I;
    end

    // live sense, fuse and boost group
    always_comb
    begin
        sense3 = 8'h00;
        sense3[pfi_pkg::FUSE_ERR_BIT] = FUSE_ERROR_I;
        sense3[pfi_pkg::FUSE_RUN_BIT] = FUSE_PROGRAM_RUNNING_I;
        sense3[pfi_pkg::BOOST_BIT] = BOOST_OVERCURRENT_I;
    end

    // flag set conditions
    always_comb
    begin
        // thermal both edges, others rising
        set0 = change_bits(sense0, state_r.prev0, pfi_pkg::BOTH0_BITS)
             | rise_bits(sense0, state_r.prev0, pfi_pkg::RISE0_BITS);
    end

    // buck 1 drives both low positions
    always_comb
    begin
        set1 = rise_bits(sense1, state_r.prev1, pfi_pkg::REG1_BITS);
    end

    // error and boost on rise, done on end of run
    always_comb
    begin
        set3 = rise_bits(sense3, state_r.prev3, pfi_pkg::RISE3_BITS)
             | fall_bits(sense3, state_r.prev3, pfi_pkg::FALL3_BITS);
    end

    // next state
    always_comb
    begin
        state_nxt = state_r;
        // edge history follows the live inputs
        state_nxt.prev0 = sense0;
        state_nxt.prev1 = sense1;
        state_nxt.prev3 = sense3;

        state_nxt.stat0 = w1c_update(state_r.stat0, set0, wr_stat0,
                                     REG_WDATA_I, pfi_pkg::REG0_BITS);
        state_nxt.stat1 = w1c_update(state_r.stat1, set1, wr_stat1,
                                     REG_WDATA_I, pfi_pkg::REG1_BITS);
        state_nxt.stat3 = w1c_update(state_r.stat3, set3, wr_stat3,
                                     REG_WDATA_I, pfi_pkg::REG3_BITS);

        // mask writes
        state_nxt.mask0 = mask_update(state_r.mask0, wr_mask0,
                                      REG_WDATA_I, pfi_pkg::REG0_BITS);
        state_nxt.mask1 = mask_update(state_r.mask1, wr_mask1,
                                      REG_WDATA_I, pfi_pkg::REG1_BITS);
        state_nxt.mask3 = mask_update(state_r.mask3, wr_mask3,
                                      REG_WDATA_I, pfi_pkg::REG3_BITS);

        // read data holds until the next read
        if (REG_RD_I)
        begin
            state_nxt.rdata = rd_value;
        end

        // unmasked flags drive the pin low
        pending = irq_pending(state_nxt);
        state_nxt.irq_n = ~pending;

        // synchronous reset, history seeded from the inputs
        if (!RST_N_I)
        begin
            state_nxt = reset_state(sense0, sense1, sense3);
        end
    end

    always_ff @(posedge CLK_I)
    begin
        state_r <= state_nxt;
    end

    assign REG_RDATA_O = state_r.rdata;
    assign IRQ_OUT_N_O = state_r.irq_n;

endmodule : pfi_fault_irq_regs

// File: hw/pfi_pkg.sv
package pfi_pkg;

    // register addresses on the serial control port
    localparam logic [7:0] STAT0_ADDR  = 8'h05;
    localparam logic [7:0] MASK0_ADDR  = 8'h06;
    localparam logic [7:0] SENSE0_ADDR = 8'h07;
    localparam logic [7:0] STAT1_ADDR  = 8'h08;
    localparam logic [7:0] MASK1_ADDR  = 8'h09;
    localparam logic [7:0] SENSE1_ADDR = 8'h0a;
    localparam logic [7:0] STAT3_ADDR  = 8'h0e;
    localparam logic [7:0] MASK3_ADDR  = 8'h0f;
    localparam logic [7:0] SENSE3_ADDR = 8'h10;

    // implemented flag, mask and sense bits per group
    localparam logic [7:0] REG0_BITS   = 8'h3f;
    localparam logic [7:0] SENSE0_BITS = 8'hbf;
    localparam logic [7:0] REG1_BITS   = 8'h1b;
    localparam logic [7:0] REG3_BITS   = 8'hc1;

    // edge kinds that set flags
    localparam logic [7:0] BOTH0_BITS  = 8'h3c;
    localparam logic [7:0] RISE0_BITS  = 8'h03;
    localparam logic [7:0] RISE3_BITS  = 8'h81;
    localparam logic [7:0] FALL3_BITS  = 8'h40;

    // field positions, group 0
    localparam int FUSE_SUPPLY_BIT = 7;
    localparam int TEMP_LSB        = 2;
    localparam int TEMP_WIDTH      = 4;
    localparam int UNDERVOLT_BIT   = 1;
    localparam int POWER_ON_BIT    = 0;

    // field positions, group 1
    localparam int BUCK3_BIT       = 4;
    localparam int BUCK2_BIT       = 3;
    localparam int BUCK1_HI_BIT    = 1;
    localparam int BUCK1_LO_BIT    = 0;

    // field positions, group 3
    localparam int FUSE_ERR_BIT    = 7;
    localparam int FUSE_RUN_BIT    = 6;
    localparam int BOOST_BIT       = 0;

    // values after reset
    localparam logic [7:0] STAT_RST  = 8'h00;
    localparam logic [7:0] MASK_RST  = 8'hff;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic       IRQ_N_RST = 1'b1;

    typedef struct packed {
        logic [7:0] prev0;
        logic [7:0] prev1;
        logic [7:0] prev3;
        logic [7:0] stat0;
        logic [7:0] mask0;
        logic [7:0] stat1;
        logic [7:0] mask1;
        logic [7:0] stat3;
        logic [7:0] mask3;
        logic [7:0] rdata;
        logic       irq_n;
    } pfi_state_s;

endpackage : pfi_pkg

// File: verification/pfi_fault_irq_monitor.sv
`timescale 1ns/1ps
module pfi_fault_irq_monitor
(
    // watched ports
    input wire logic       CLK_I, RST_N_I, FUSE_SUPPLY_PIN_I, INPUT_UNDERVOLT_I, POWER_ON_PIN_I,
    input wire logic       BUCK3_OVERCURRENT_I, BUCK2_OVERCURRENT_I, BUCK1_OVERCURRENT_I,
    input wire logic       FUSE_ERROR_I, FUSE_PROGRAM_RUNNING_I, BOOST_OVERCURRENT_I,
    input wire logic       REG_WR_I, REG_RD_I, IRQ_OUT_N_O,
    input wire logic [3:0] TEMP_ABOVE_I,
    input wire logic [7:0] REG_ADDR_I, REG_RDATA_O
);
    wire logic [11:0] ins = {TEMP_ABOVE_I, INPUT_UNDERVOLT_I, POWER_ON_PIN_I,
        BUCK3_OVERCURRENT_I, BUCK2_OVERCURRENT_I, BUCK1_OVERCURRENT_I,
        FUSE_ERROR_I, FUSE_PROGRAM_RUNNING_I, BOOST_OVERCURRENT_I};
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    property pf(ev, a, m);
        ev ##1 (REG_RD_I && !REG_WR_I && REG_ADDR_I == a) |=> (REG_RDATA_O & m) == m;
    endproperty
    AST_SENSE0: assert property (
        REG_RD_I && REG_ADDR_I == 8'h07 |=> REG_RDATA_O == {$past(FUSE_SUPPLY_PIN_I), 1'b0,
        $past(TEMP_ABOVE_I), $past(INPUT_UNDERVOLT_I), $past(POWER_ON_PIN_I)})
        else $error("sense0 wrong");
    AST_SENSE1: assert property (REG_RD_I && REG_ADDR_I == 8'h0a |=>
        REG_RDATA_O == {3'h0, $past(BUCK3_OVERCURRENT_I), $past(BUCK2_OVERCURRENT_I), 1'b0,
        {2{$past(BUCK1_OVERCURRENT_I)}}}) else $error("sense1 wrong");
    AST_IRQ_SET: assert property ($fell(IRQ_OUT_N_O) |->
        $past(REG_WR_I) || $past(ins) != $past(ins, 2)) else $error("irq without cause");
    AST_IRQ_CLR: assert property ($rose(IRQ_OUT_N_O) |-> $past(REG_WR_I))
        else $error("irq released alone");
    AST_BUCK3: assert property (pf($rose(BUCK3_OVERCURRENT_I), 8'h08, 8'h10))
        else $error("buck3 flag");
    AST_BUCK1: assert property (pf($rose(BUCK1_OVERCURRENT_I), 8'h08, 8'h03))
        else $error("buck1 flags");
    AST_THERM: assert property (pf($changed(TEMP_ABOVE_I[3]), 8'h05, 8'h20))
        else $error("thermal flag");
    AST_DONE: assert property (pf($fell(FUSE_PROGRAM_RUNNING_I), 8'h0e, 8'h40))
        else $error("fuse done flag");
    cover property ($fell(IRQ_OUT_N_O));
    cover property ($rose(IRQ_OUT_N_O));
    cover property (REG_RD_I && REG_ADDR_I == 8'h0e);
endmodule : pfi_fault_irq_monitor
bind pfi_fault_irq_regs pfi_fault_irq_monitor u_pfi_fault_irq_monitor (.*);

// File: verification/pfi_host_model.sv
`timescale 1ns/1ps
module pfi_host_model
(
    // register port
    input  wire logic       CLK_I,
    input  wire logic [7:0] REG_RDATA_O,
    output logic            REG_WR_I, REG_RD_I,
    output logic      [7:0] REG_ADDR_I, REG_WDATA_I
);
    initial {REG_WR_I, REG_RD_I, REG_ADDR_I, REG_WDATA_I} = 18'h0;
    task wr(input logic [7:0] a, d); // ones clear flags
        @(posedge CLK_I) #1;
        {REG_ADDR_I, REG_WDATA_I, REG_WR_I} = {a, d, 1'b1};
        @(posedge CLK_I) #1;
        REG_WR_I = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d); // no fuse test space
        @(posedge CLK_I) #1;
        {REG_ADDR_I, REG_RD_I} = {a, 1'b1};
        @(posedge CLK_I) #1;
        REG_RD_I = 1'b0;
        d = REG_RDATA_O;
    endtask : rd
endmodule : pfi_host_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic CLK_I = 1'b0, RST_N_I = 1'b0, FUSE_SUPPLY_PIN_I = 1'b1, POWER_ON_PIN_I = 1'b1;
    logic INPUT_UNDERVOLT_I = 1'b0, BUCK3_OVERCURRENT_I = 1'b0, BUCK2_OVERCURRENT_I = 1'b1;
    logic BUCK1_OVERCURRENT_I = 1'b0, FUSE_ERROR_I = 1'b0, FUSE_PROGRAM_RUNNING_I = 1'b0;
    logic BOOST_OVERCURRENT_I = 1'b0, REG_WR_I, REG_RD_I, IRQ_OUT_N_O;
    logic [3:0] TEMP_ABOVE_I = 4'h1;
    logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O;
    int n_fail = 0, cmp_count = 0;
    pfi_fault_irq_regs u_pfi_fault_irq_regs (.*);
    pfi_host_model u_pfi_host_model (.*);
    initial forever #10 CLK_I = ~CLK_I;
    initial #20us stop_test(1);
    task cmp(input logic [7:0] g, e);
        cmp_count++;
        n_fail += int'(g !== e);
        if (g !== e)
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
    endtask : cmp
    task chk(input logic [7:0] a, e);
        logic [7:0] d;
        u_pfi_host_model.rd(a, d);
        cmp(d, e);
    endtask : chk
    task stop_test(input int extra);
        n_fail += extra;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (5) @(posedge CLK_I);
        #1 RST_N_I = 1'b1;
        chk(8'h07, 8'h85);
        chk(8'h0a, 8'h08);
        chk(8'h09, 8'h1b);
        {FUSE_SUPPLY_PIN_I, TEMP_ABOVE_I, INPUT_UNDERVOLT_I, POWER_ON_PIN_I} = 7'h3e;
        chk(8'h05, 8'h3a);
        chk(8'h07, 8'h3e);
        $display("sense test done");
        BUCK2_OVERCURRENT_I = 1'b0;
        chk(8'h08, 8'h00);
        {BUCK3_OVERCURRENT_I, BUCK2_OVERCURRENT_I, BUCK1_OVERCURRENT_I} = 3'h7;
        chk(8'h08, 8'h1b);
        chk(8'h0a, 8'h1b);
        u_pfi_host_model.wr(8'h08, 8'h00);
        chk(8'h08, 8'h1b);
        cmp({7'h0, IRQ_OUT_N_O}, 8'h01);
        u_pfi_host_model.wr(8'h09, 8'h00);
        cmp({7'h0, IRQ_OUT_N_O}, 8'h00);
        u_pfi_host_model.wr(8'h08, 8'h1b);
        cmp({7'h0, IRQ_OUT_N_O}, 8'h01);
        $display("buck test done");
        fork
            u_pfi_host_model.wr(8'h0e, 8'h01);
            @(posedge CLK_I) #1 BOOST_OVERCURRENT_I = 1'b1;
        join
        chk(8'h0e, 8'h01);
        FUSE_PROGRAM_RUNNING_I = 1'b1;
        chk(8'h10, 8'h41);
        {FUSE_PROGRAM_RUNNING_I, FUSE_ERROR_I} = 2'h1;
        chk(8'h0e, 8'hc1);
        u_pfi_host_model.wr(8'h05, 8'h3f);
        TEMP_ABOVE_I = 4'h7;
        chk(8'h05, 8'h20);
        $display("fuse test done");
        stop_test(0);
    end
endmodule : tb_top
